// *** bfrc_bridge_fault_reset_control.sv ***
`timescale 1ns/1ps
module bfrc_bridge_fault_reset_control #(
    parameter int STUCK_CYC = bfrc_pkg::STUCK_LIMIT_CYC
) (
    input  wire logic                          clk_sys_in,            // system clock
    input  wire logic                          rst_n_in,              // power-on reset
    input  wire logic                          gate_supply_good_in,   // gate supply above por level
    input  wire logic                          logic_supply_good_in,  // logic supply above por level
    input  wire logic                          gate_supply_uv_in,     // gate supply undervoltage
    input  wire logic                          logic_supply_uv_in,    // logic supply undervoltage
    input  wire logic                          pair_first_reset_n,    // pair ab reset, active low
    input  wire logic                          pair_second_reset_n,   // pair cd reset, active low
    input  wire logic                          out_mode_in,           // 0 bridge-tied, 1 single-ended
    input  wire logic                          latch_mode_in,         // latching shutdown mode
    input  wire logic [bfrc_pkg::NUM_PAIRS-1:0] overload_in,          // persisted overload per pair
    input  wire logic [bfrc_pkg::NUM_PAIRS-1:0] overcurrent_in,       // instantaneous overcurrent
    input  wire logic [bfrc_pkg::NUM_PWM-1:0]   pwm_in,               // pwm inputs a..d
    output logic      [bfrc_pkg::NUM_PAIRS-1:0] pair_hiz_out,         // pair outputs high impedance
    output logic      [bfrc_pkg::NUM_PAIRS-1:0] pair_pulldown_out,    // weak pulldown enable
    output logic      [bfrc_pkg::NUM_PAIRS-1:0] overload_latch_out,   // overload latch state
    output logic                               supply_undervoltage_guard_out, // uv shutdown
    output logic                               fault_out_n            // fault, active low
);
    import bfrc_pkg::*;

    // ==========================================================
    // state
    // ==========================================================
    typedef struct packed {
        bfrc_sup_state_t        sup;         // supply state
        logic [NUM_PAIRS-1:0]   rst_last;    // previous reset levels
        logic [NUM_PAIRS-1:0]   olatch;      // overload latch per pair
        logic [NUM_PAIRS-1:0]   hiz;         // registered hi-z controls
        logic [NUM_PAIRS-1:0]   pd;          // registered pulldowns
        logic                   fault_n;     // registered fault output
    } bfrc_state_t;

    bfrc_state_t st_reg;                     // registered state
    bfrc_state_t st_next;                    // next state

    logic [NUM_PWM-1:0]   stuck;             // stuck pwm flags
    logic [NUM_PAIRS-1:0] rst_low;           // reset asserted per pair
    logic [NUM_PAIRS-1:0] rst_rise;          // reset rising edge per pair
    logic [NUM_PAIRS-1:0] pair_stuck;        // stuck input in pair
    logic [NUM_PAIRS-1:0] ol_set;            // overload set request
    logic                 any_uv;            // any supply under threshold
    logic                 sup_ok;            // supply state allows running

    // ==========================================================
    // stuck input detector
    // ==========================================================
    bfrc_stuck_detect #(
        .N     (NUM_PWM),
        .LIMIT (STUCK_CYC)
    ) u_stuck (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .pwm_in     (pwm_in),
        .stuck_out  (stuck)
    );

    // ==========================================================
    // next-state logic
    // ==========================================================
    always_comb begin
        st_next = st_reg;
        rst_low  = {~pair_second_reset_n, ~pair_first_reset_n};
        rst_rise = ~rst_low & st_reg.rst_last;
        st_next.rst_last = rst_low;
        any_uv = gate_supply_uv_in | logic_supply_uv_in;
        pair_stuck = {stuck[3] | stuck[2], stuck[1] | stuck[0]};

        // supply sequencing
        case (st_reg.sup)
            SUP_POR: begin
                if (gate_supply_good_in && logic_supply_good_in && !any_uv) begin
                    st_next.sup = SUP_RUN;
                end
            end
            SUP_RUN: begin
                if (any_uv) begin
                    st_next.sup = SUP_UV;
                end
            end
            SUP_UV: begin
                if (!any_uv) begin
                    st_next.sup = SUP_RUN;
                end
            end
            default: begin
                st_next.sup = SUP_POR;
            end
        endcase
        sup_ok = (st_reg.sup == SUP_RUN) && !any_uv;

        // overload latch per pair
        for (int p = 0; p < NUM_PAIRS; p++) begin
            // latch only this pair; overcurrent latches in latching mode
            ol_set[p] = overload_in[p] | (latch_mode_in & overcurrent_in[p]);
            if (st_reg.sup == SUP_POR) begin
                st_next.olatch[p] = 1'b0;
            end else if (ol_set[p] && !rst_low[p]) begin
                // set wins over clear
                st_next.olatch[p] = 1'b1;
            end else if (rst_rise[0] || rst_rise[1]) begin
                st_next.olatch[p] = 1'b0;
            end
        end

        for (int p = 0; p < NUM_PAIRS; p++) begin
            // reset forces pair hi-z; uv forces all
            st_next.hiz[p] = !sup_ok | rst_low[p] | st_next.olatch[p] | pair_stuck[p];
            st_next.pd[p] = rst_low[p] && (out_mode_in == OUT_MODE_BTL);
        end

        // fault output
        if (rst_low != '0) begin
            st_next.fault_n = 1'b1;
        end else begin
            // uv outside power-on or latched overload pulls fault low; stuck does not
            st_next.fault_n = !((st_reg.sup == SUP_UV) || any_uv && st_reg.sup != SUP_POR
                                || st_next.olatch != '0);
        end
    end

    // ==========================================================
    // state register
    // ==========================================================
    // registered outputs
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_reg.sup      <= SUP_POR;
            st_reg.rst_last <= '0;
            st_reg.olatch   <= '0;
            st_reg.hiz      <= {NUM_PAIRS{HIZ_RST}};
            st_reg.pd       <= {NUM_PAIRS{PD_RST}};
            st_reg.fault_n  <= FAULT_N_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // outputs
    // ==========================================================
    assign pair_hiz_out                  = st_reg.hiz;
    assign pair_pulldown_out             = st_reg.pd;
    assign overload_latch_out            = st_reg.olatch;
    assign supply_undervoltage_guard_out = (st_reg.sup == SUP_UV);
    assign fault_out_n                   = st_reg.fault_n;
endmodule

// *** bfrc_pkg.sv ***
package bfrc_pkg;
    // ==========================================================
    // pair indices
    // ==========================================================
    localparam int PAIR_AB = 0;                 // half-bridges a and b
    localparam int PAIR_CD = 1;                 // half-bridges c and d
    localparam int NUM_PAIRS = 2;               // two reset domains
    localparam int NUM_PWM = 4;                 // one pwm input per half-bridge

    // ==========================================================
    // timing
    // ==========================================================
    localparam int CLK_PERIOD_PS = 25000;       // 40 mhz system clock
    localparam int STUCK_LIMIT_NS = 15000;      // stuck pwm input limit, 15 us
    // longest time rounds down
    localparam int STUCK_LIMIT_CYC = (STUCK_LIMIT_NS * 1000) / CLK_PERIOD_PS;

    // ==========================================================
    // mode encodings
    // ==========================================================
    // output mode: bridge-tied or single-ended
    localparam logic OUT_MODE_BTL = 1'b0;
    localparam logic OUT_MODE_SE  = 1'b1;

    // ==========================================================
    // reset values
    // ==========================================================
    localparam logic FAULT_N_RST = 1'b1;        // fault output released
    localparam logic HIZ_RST     = 1'b1;        // outputs held in high impedance
    localparam logic PD_RST      = 1'b0;        // pulldowns off

    // ==========================================================
    // supply state machine, one-hot
    // ==========================================================
    typedef enum logic [2:0] {
        SUP_POR  = 3'b001,                      // power-on, waiting for supplies
        SUP_RUN  = 3'b010,                      // supplies good
        SUP_UV   = 3'b100                       // undervoltage shutdown
    } bfrc_sup_state_t;
endpackage

// *** bfrc_stuck_detect.sv ***
`timescale 1ns/1ps
// ==========================================================
// stuck pwm input detector, one counter per input
// ==========================================================
module bfrc_stuck_detect #(
    parameter int N     = 4,
    parameter int LIMIT = 600
) (
    input  wire logic         clk_sys_in,   // system clock
    input  wire logic         rst_n_in,     // async reset, active low
    input  wire logic [N-1:0] pwm_in,       // pwm inputs
    output logic      [N-1:0] stuck_out     // input held past limit
);
    import bfrc_pkg::*;

    localparam int CW = $clog2(LIMIT + 1);  // counter width

    // ==========================================================
    // state
    // ==========================================================
    typedef struct packed {
        logic [N-1:0][CW-1:0] cnt;          // cycles since last edge
        logic [N-1:0]         last;         // previous input level
        logic [N-1:0]         stuck;        // stuck flags
    } bfrc_sd_state_t;

    bfrc_sd_state_t st_reg;                 // registered state
    bfrc_sd_state_t st_next;                // next state

    // next-state logic for every input
    always_comb begin
        st_next = st_reg;
        for (int i = 0; i < N; i++) begin
            st_next.last[i] = pwm_in[i];
            // any edge restarts the count
            if (pwm_in[i] != st_reg.last[i]) begin
                st_next.cnt[i] = '0;
            end else if (st_reg.cnt[i] != CW'(LIMIT)) begin
                st_next.cnt[i] = st_reg.cnt[i] + CW'(1);
            end
            st_next.stuck[i] = (st_next.cnt[i] == CW'(LIMIT));
        end
    end

    // state register
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign stuck_out = st_reg.stuck;
endmodule

// *** bfrc_properties.sv ***
`timescale 1ns/1ps
// ==========================================================
// protection and reset properties
// ==========================================================
module bfrc_properties #(parameter int STUCK_CYC = 8) (
    input wire logic       clk_sys_in, rst_n_in, gate_supply_good_in, logic_supply_good_in,
    input wire logic       gate_supply_uv_in, logic_supply_uv_in, pair_first_reset_n,
    input wire logic       pair_second_reset_n, out_mode_in, latch_mode_in,
    input wire logic [1:0] overload_in, overcurrent_in, pair_hiz_out, pair_pulldown_out,
    input wire logic [1:0] overload_latch_out,
    input wire logic [3:0] pwm_in,
    input wire logic       supply_undervoltage_guard_out, fault_out_n
);
    import bfrc_pkg::*;
    logic       sup_seen_reg;   // supplies good once since reset
    logic [3:0] pwm_last_reg;   // pwm of last cycle
    int         hold_cnt_reg;   // cycles with pwm unchanged
    wire        uv_any = gate_supply_uv_in | logic_supply_uv_in;
    // power-up and frozen pwm tracking
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sup_seen_reg <= 1'b0;
            pwm_last_reg <= 4'h0;
            hold_cnt_reg <= 0;
        end else begin
            sup_seen_reg <= sup_seen_reg | (gate_supply_good_in & logic_supply_good_in & ~uv_any);
            pwm_last_reg <= pwm_in;
            hold_cnt_reg <= (pwm_in == pwm_last_reg) ? hold_cnt_reg + 1 : 0;
        end
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    sequence rise_s; $rose(pair_first_reset_n) || $rose(pair_second_reset_n); endsequence
    sequence quiet_s; overload_in == 2'b00 && overcurrent_in == 2'b00; endsequence
    por_hold_a: assert property (!sup_seen_reg |-> pair_hiz_out == 2'b11 && fault_out_n)
        else $error("outputs active before supplies good");
    uv_fault_a: assert property (supply_undervoltage_guard_out && uv_any &&
        pair_first_reset_n && pair_second_reset_n |=> pair_hiz_out == 2'b11 && !fault_out_n)
        else $error("undervoltage not shut down");
    first_off_a: assert property (!pair_first_reset_n |=> pair_hiz_out[0])
        else $error("pair ab driving in reset");
    second_off_a: assert property (!pair_second_reset_n |=> pair_hiz_out[1])
        else $error("pair cd driving in reset");
    ovl_latch_a: assert property (sup_seen_reg && overload_in[0] && pair_first_reset_n
        |=> overload_latch_out[0] && pair_hiz_out[0]) else $error("pair ab overload not latched");
    pd_btl_a: assert property (out_mode_in == OUT_MODE_BTL && !pair_second_reset_n
        |=> pair_pulldown_out[1]) else $error("pulldown cd off in reset");
    pd_se_a: assert property (out_mode_in == OUT_MODE_SE |=> pair_pulldown_out == 2'b00)
        else $error("pulldown on in single-ended mode");
    rst_quiet_a: assert property (
        !(pair_first_reset_n && pair_second_reset_n) |=> fault_out_n)
        else $error("fault shown while reset low");
    latch_clear_a: assert property (
        rise_s ##0 quiet_s |-> ##[1:2] overload_latch_out == 2'b00)
        else $error("latch kept after reset edge");
    stuck_hiz_a: assert property (hold_cnt_reg >= STUCK_CYC + 3 |-> pair_hiz_out == 2'b11)
        else $error("frozen pwm left outputs driving");
endmodule

// *** bfrc_ctrl_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// modulator and controller model
// ==========================================================
module bfrc_ctrl_model (
    input  wire logic       clk_sys_in,          // system clock
    input  wire logic [1:0] rst_req_in,          // hold a pair in reset
    input  wire logic       freeze_in,           // stop pwm switching
    output logic            first_n_out = 1'b1,  // pair ab reset
    output logic            second_n_out = 1'b1, // pair cd reset
    output logic      [3:0] pwm_out = 4'h5       // pwm a..d
);
    // reset per pair, pwm low on release
    logic [3:0] pwm_nxt;     // toggled or frozen pwm levels
    always @(*) begin
        pwm_nxt = freeze_in ? pwm_out : ~pwm_out;
        if (!rst_req_in[0] && !first_n_out)
            pwm_nxt[1:0] = 2'b00;
        if (!rst_req_in[1] && !second_n_out)
            pwm_nxt[3:2] = 2'b00;
    end
    always @(posedge clk_sys_in) begin
        {second_n_out, first_n_out} <= ~rst_req_in;
        pwm_out <= pwm_nxt;
    end
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
// ==========================================================
// bench top
// ==========================================================
module tb_top;
    import bfrc_pkg::*;
    localparam int STUCK_CYC = 8;   // shortened stuck limit
    logic clk_sys_in = 1'b0, rst_n_in = 1'b0, gate_supply_good_in = 1'b0;
    logic logic_supply_good_in = 1'b0, gate_supply_uv_in = 1'b0, logic_supply_uv_in = 1'b0;
    logic out_mode_in = 1'b0, latch_mode_in = 1'b0, frz = 1'b0;
    logic pair_first_reset_n, pair_second_reset_n, supply_undervoltage_guard_out, fault_out_n;
    logic [1:0] overload_in = 2'b00, overcurrent_in = 2'b00, req = 2'b00;
    logic [1:0] pair_hiz_out, pair_pulldown_out, overload_latch_out;
    logic [3:0] pwm_in;
    int miscompares = 0, samples_checked = 0, cycles = 0, p;
    always #12.5 clk_sys_in = ~clk_sys_in;
    bfrc_ctrl_model bfrc_ctrl_model_i (.clk_sys_in, .rst_req_in(req), .freeze_in(frz),
        .first_n_out(pair_first_reset_n), .second_n_out(pair_second_reset_n), .pwm_out(pwm_in));
    bfrc_bridge_fault_reset_control #(.STUCK_CYC(STUCK_CYC)) bfrc_bridge_fault_reset_control_i (
        .clk_sys_in, .rst_n_in, .gate_supply_good_in, .logic_supply_good_in, .gate_supply_uv_in,
        .logic_supply_uv_in, .pair_first_reset_n, .pair_second_reset_n, .out_mode_in,
        .latch_mode_in, .overload_in, .overcurrent_in, .pwm_in, .pair_hiz_out, .pair_pulldown_out,
        .overload_latch_out, .supply_undervoltage_guard_out, .fault_out_n);
    // wait n edges, then drive just after
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_in);
        #2;
    endtask
    task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // cycle ceiling against hangs
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    initial begin
        void'($urandom(32'h5b1fd88d));
        step(4);
        rst_n_in = 1'b1;
        step(2);
        chk("por hiz", 2'b11, pair_hiz_out);
        {gate_supply_good_in, logic_supply_good_in} = 2'b11;
        step(2);
        chk("run hiz", 2'b00, pair_hiz_out);
        for (int s = 0; s < 2; s++) begin
            {logic_supply_uv_in, gate_supply_uv_in} = 2'(1 << s);
            step(2);
            chk("uv fault", 2'b01, {fault_out_n, supply_undervoltage_guard_out});
            {logic_supply_uv_in, gate_supply_uv_in} = 2'b00;
            step(2);
            chk("resume", 2'b10, {fault_out_n, supply_undervoltage_guard_out});
            chk("resume hiz", 2'b00, pair_hiz_out);
        end
        for (int m = 0; m < 4; m++) begin
            out_mode_in = m[1];
            req = 2'(1 << m[0]);
            step(2);
            chk("rst hiz", req, pair_hiz_out);
            chk("pulldown", m[1] ? 2'b00 : req, pair_pulldown_out);
            chk("rst fault", 2'b01, fault_out_n);
            req = 2'b00;
            step(3);
        end
        out_mode_in = OUT_MODE_BTL;
        for (int i = 0; i < 4; i++) begin
            p = (i < 2) ? i : int'($urandom % 2);
            overload_in[p] = 1'b1;
            step(1);
            overload_in = 2'b00;
            step(2);
            chk("latch", 2'(1 << p), overload_latch_out);
            chk("ovl hiz", 2'(1 << p), pair_hiz_out);
            chk("ovl fault", 2'b00, fault_out_n);
            // wait before recovery
            step(40);
            req = 2'(1 + $urandom % 3);
            step(2);
            chk("masked fault", 2'b01, fault_out_n);
            req = 2'b00;
            step(3);
            chk("cleared", 2'b00, overload_latch_out | pair_hiz_out);
        end
        for (int l = 0; l < 2; l++) begin
            latch_mode_in = l[0];
            overcurrent_in = 2'b10;
            step(1);
            overcurrent_in = 2'b00;
            step(2);
            chk("oc latch", l ? 2'b10 : 2'b00, overload_latch_out);
            req = 2'b11;
            step(2);
            req = 2'b00;
            step(3);
        end
        frz = 1'b1;
        step(STUCK_CYC + 4);
        chk("stuck hiz", 2'b11, pair_hiz_out);
        chk("stuck fault", 2'b01, fault_out_n);
        tally_and_finish();
    end
endmodule
bind bfrc_bridge_fault_reset_control bfrc_properties #(.STUCK_CYC(STUCK_CYC)) bfrc_properties_i (.*);
